// ===== hw/sci_control_status.sv
// Control-two and status-one logic of an asynchronous serial interface, with a small transmit engine.
// Assumes synchronous register strobes and a receiver outside that reports character events.

// What this block does
// - Bit 7 enables an interrupt while the transmit buffer empty flag is set.
// - Bit 6 enables an interrupt while the transmission done flag is set.
// - Bit 5 enables an interrupt while the receive buffer full flag is set.
// - Bit 4 enables an interrupt while the line idle flag is set.
// - Bit 3 enables the transmitter, which then drives the transmit pin.
// - In single-wire mode the direction bit decides transmit pin direction.
// - Rewriting transmitter enable from 0 to 1 queues one idle character.
// - After disabling, the pin is kept until pending characters finish.
// - Bit 2 enables the receiver; when off the receive pin is released.
// - Writing bit 1 puts the receiver into wake-up standby.
// - Wake on idle line or on data MSB set, by wake select.
// - Software sets standby; the wake-up condition clears it automatically.
// - Writing 1 then 0 to bit 0 queues one break character.
// - Breaks repeat while bit 0 stays 1; 10 or 13 bit times long.
// - Status at 0x44 holds eight read-only flags; writes do nothing.
// - Flags clear only through status-read then data-access sequences; transmit done also through status-read then a control write raising bit 3 or 0.
// - Status resets to transmit empty and done set, others clear.
// - Baud generator stays off until transmitter or receiver enable is first written 1.
// - Transmit empty clears on status read with flag set, then data write.
module sci_control_status #(
	parameter int OVERSAMPLE = 16
) (
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	input  wire sci_ctl_pkg::bus_req_s reg_req,
	output logic [7:0]                 rd_data,
	input  wire sci_ctl_pkg::rx_event_s rx_evt,
	output logic                       irq_req,
	output logic                       tx_pin_out,
	output logic                       tx_pin_oe,
	output logic                       rx_pin_released
);
	import sci_ctl_pkg::*;

	if (OVERSAMPLE < 1 || OVERSAMPLE > 16) begin : g_check
		$error("OVERSAMPLE must lie in 1..16");
	end

	sci_state_s s_reg;
	sci_state_s s_next;

	function automatic logic hit(input bus_req_s r, input logic [7:0] ofs, input logic is_wr);
		hit = (is_wr ? r.wr : r.rd) && (r.addr == ofs);
	endfunction : hit

	logic        wr_ctrl;
	logic        wr_cfg;
	logic        wr_div;
	logic        wr_data;
	logic        rd_status;
	logic        rd_data_reg;
	logic        baud_tick;
	logic [11:0] presc_limit;
	logic        single_wire;
	logic        tx_owns;
	logic        wake;
	logic [7:0]  st_set;
	logic [7:0]  st_clr;

	always_comb begin
		s_next      = s_reg;
		wr_ctrl     = hit(reg_req, CTRL_OFS, 1'b1);
		wr_cfg      = hit(reg_req, CFG_OFS, 1'b1);
		wr_div      = hit(reg_req, DIV_OFS, 1'b1);
		wr_data     = hit(reg_req, DATA_OFS, 1'b1);
		rd_status   = hit(reg_req, STATUS_OFS, 1'b0);
		rd_data_reg = hit(reg_req, DATA_OFS, 1'b0);
		st_set      = 8'h00;
		st_clr      = 8'h00;

		// Register writes; status has no write path
		if (wr_cfg)
			s_next.cfg = reg_req.wdata;
		if (wr_div)
			s_next.div = reg_req.wdata;
		if (wr_data)
			s_next.tx_buf = reg_req.wdata;

		// Hardware clears standby on the selected wake condition
		wake = s_reg.ctrl[CTRL_RX_STANDBY_REQ] &&
			((!s_reg.cfg[CFG_WAKE_SEL] && rx_evt.idle_det) ||
			(s_reg.cfg[CFG_WAKE_SEL] && rx_evt.char_valid && rx_evt.char_data[7]));
		if (wake)
			s_next.ctrl[CTRL_RX_STANDBY_REQ] = 1'b0;

		if (wr_ctrl) begin
			s_next.ctrl = reg_req.wdata;
			if (reg_req.wdata[CTRL_TX_ENABLE] && !s_reg.ctrl[CTRL_TX_ENABLE]) begin
				s_next.idle_pend = 1'b1;
				if (s_reg.armed[ST_TX_DONE])
					st_clr[ST_TX_DONE] = 1'b1;
			end
			if (reg_req.wdata[CTRL_QUEUE_BREAK] && !s_reg.ctrl[CTRL_QUEUE_BREAK]) begin
				s_next.break_pend = 1'b1;
				if (s_reg.armed[ST_TX_DONE])
					st_clr[ST_TX_DONE] = 1'b1;
			end
			if (reg_req.wdata[CTRL_TX_ENABLE] || reg_req.wdata[CTRL_RX_ENABLE])
				s_next.baud_run = 1'b1;
		end

		// Clearing sequences: status read arms, data access consumes
		if (rd_status)
			s_next.armed = s_reg.status;
		if (wr_data) begin
			st_clr[ST_TX_BUF_EMPTY] = s_reg.armed[ST_TX_BUF_EMPTY];
			st_clr[ST_TX_DONE] = st_clr[ST_TX_DONE] | s_reg.armed[ST_TX_DONE];
			s_next.armed[7:6] = 2'b00;
		end
		if (rd_data_reg) begin
			st_clr[5:0] = s_reg.armed[5:0];
			s_next.armed[5:0] = 6'h00;
		end

		// Receive events, suppressed while in standby
		if (rx_evt.char_valid && !s_reg.ctrl[CTRL_RX_STANDBY_REQ] && s_reg.ctrl[CTRL_RX_ENABLE]) begin
			if (s_reg.status[ST_RX_BUF_FULL] && !st_clr[ST_RX_BUF_FULL]) begin
				st_set[ST_OVERRUN] = 1'b1;
			end else begin
				st_set[ST_RX_BUF_FULL] = 1'b1;
				st_set[ST_NOISE]       = rx_evt.noise;
				st_set[ST_FRAMING_ERR] = rx_evt.frame_err;
				st_set[ST_PARITY_ERR]  = rx_evt.parity_err;
				s_next.rx_data         = rx_evt.char_data;
				s_next.idle_rearm      = 1'b1;
			end
		end
		if (rx_evt.idle_det && s_reg.idle_rearm && !s_reg.ctrl[CTRL_RX_STANDBY_REQ]
			&& s_reg.ctrl[CTRL_RX_ENABLE]) begin
			st_set[ST_LINE_IDLE] = 1'b1;
			s_next.idle_rearm    = 1'b0;
		end

		// Bit-rate prescaler, idle until first enable
		presc_limit = 12'(s_reg.div * OVERSAMPLE) - 12'h001;
		baud_tick   = s_reg.baud_run && (s_reg.div != 8'h00) && (s_reg.presc == presc_limit);
		if (!s_reg.baud_run || s_reg.div == 8'h00 || baud_tick)
			s_next.presc = 12'h000;
		else
			s_next.presc = s_reg.presc + 12'h001;

		// Transmit engine
		unique case (s_reg.tx_state)
			TX_IDLE: begin
				if (s_reg.break_pend || s_reg.ctrl[CTRL_QUEUE_BREAK]) begin
					s_next.tx_state   = TX_BREAK;
					s_next.shift      = 13'h0000;
					s_next.bit_cnt    = s_reg.cfg[CFG_LONG_BREAK_SEL] ? LONG_BREAK_BITS : FRAME_BITS;
					s_next.break_pend = 1'b0;
				end else if (s_reg.idle_pend) begin
					s_next.tx_state  = TX_PREAMBLE;
					s_next.shift     = 13'h1FFF;
					s_next.bit_cnt   = FRAME_BITS;
					s_next.idle_pend = 1'b0;
				end else if (s_reg.ctrl[CTRL_TX_ENABLE] && !s_reg.status[ST_TX_BUF_EMPTY]) begin
					s_next.tx_state = TX_DATA;
					s_next.shift    = {3'h7, 1'b1, s_reg.tx_buf, 1'b0};
					s_next.bit_cnt  = FRAME_BITS;
					st_set[ST_TX_BUF_EMPTY] = 1'b1;
				end
				if (baud_tick)
					s_next.tx_out = 1'b1;
			end
			TX_DATA, TX_BREAK, TX_PREAMBLE: begin
				if (baud_tick) begin
					if (s_reg.bit_cnt == 4'h0) begin
						s_next.tx_state = TX_IDLE;
						s_next.tx_out   = 1'b1;
					end else begin
						s_next.tx_out  = s_reg.shift[0];
						s_next.shift   = {1'b1, s_reg.shift[12:1]};
						s_next.bit_cnt = s_reg.bit_cnt - 4'h1;
					end
				end
			end
			default: begin
				s_next.tx_state = TX_IDLE;
			end
		endcase

		// Flags: a hardware set wins over a software clear
		s_next.status = (s_reg.status & ~st_clr) | st_set;
		if (s_next.status[ST_TX_BUF_EMPTY] && s_next.tx_state == TX_IDLE && !s_next.break_pend
			&& !s_next.idle_pend && !s_next.ctrl[CTRL_QUEUE_BREAK])
			s_next.status[ST_TX_DONE] = 1'b1;

		// Pin ownership held until queued work drains
		tx_owns     = s_next.ctrl[CTRL_TX_ENABLE] || s_next.tx_state != TX_IDLE || s_next.break_pend
			|| s_next.idle_pend;
		single_wire = s_next.cfg[CFG_LOOPBACK_SEL] && s_next.cfg[CFG_RX_SOURCE_SEL];
		s_next.tx_oe = tx_owns && (!single_wire || s_next.cfg[CFG_SINGLE_WIRE_DIR]);
		s_next.rx_released = !s_next.ctrl[CTRL_RX_ENABLE] || s_next.cfg[CFG_LOOPBACK_SEL];

		// One combined request from enabled flags
		s_next.irq = |(s_reg.ctrl[7:4] & s_reg.status[7:4]);

		// Read data stands one cycle only
		s_next.rd_data = 8'h00;
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				STATUS_OFS: s_next.rd_data = s_reg.status;
				CTRL_OFS:   s_next.rd_data = s_reg.ctrl;
				CFG_OFS:    s_next.rd_data = s_reg.cfg;
				DIV_OFS:    s_next.rd_data = s_reg.div;
				DATA_OFS:   s_next.rd_data = s_reg.rx_data;
				default:    s_next.rd_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg             <= '0;
			s_reg.ctrl        <= CTRL_RESET;
			s_reg.cfg         <= CFG_RESET;
			s_reg.div         <= DIV_RESET;
			s_reg.status      <= STATUS_RESET;
			s_reg.tx_state    <= TX_IDLE;
			s_reg.tx_out      <= 1'b1;
			s_reg.rx_released <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rd_data         = s_reg.rd_data;
	assign irq_req         = s_reg.irq;
	assign tx_pin_out      = s_reg.tx_out;
	assign tx_pin_oe       = s_reg.tx_oe;
	assign rx_pin_released = s_reg.rx_released;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence arm_tx_empty;
		reg_req.rd && reg_req.addr == STATUS_OFS && s_reg.status[ST_TX_BUF_EMPTY];
	endsequence
	sequence write_data_word;
		reg_req.wr && reg_req.addr == DATA_OFS;
	endsequence
	sequence toggle_tx_enable;
		reg_req.wr && reg_req.addr == CTRL_OFS && reg_req.wdata[CTRL_TX_ENABLE] && !s_reg.ctrl[CTRL_TX_ENABLE];
	endsequence
	// One cycle without a data write between the status read and the data write
	sequence gap_then_write;
		!(reg_req.wr && reg_req.addr == DATA_OFS) ##1 write_data_word;
	endsequence

	chk_irq_tx_empty: assert property (s_reg.ctrl[7] && s_reg.status[7] |=> irq_req)
		else $error("transmit empty interrupt missing");
	chk_irq_tx_done: assert property (s_reg.ctrl[6] && s_reg.status[6] |=> irq_req)
		else $error("transmit done interrupt missing");
	chk_irq_rx_full: assert property (s_reg.ctrl[5] && s_reg.status[5] |=> irq_req)
		else $error("receive full interrupt missing");
	chk_irq_line_idle: assert property (s_reg.ctrl[4] && s_reg.status[4] |=> irq_req)
		else $error("idle interrupt missing");
	chk_irq_quiet: assert property ((s_reg.ctrl[7:4] & s_reg.status[7:4]) == 4'h0 |=> !irq_req)
		else $error("interrupt without enabled flag");
	chk_tx_pin_owned: assert property (s_reg.ctrl[CTRL_TX_ENABLE] && !s_reg.cfg[CFG_LOOPBACK_SEL] ##1
		$stable(s_reg.ctrl) && $stable(s_reg.cfg) |-> tx_pin_oe)
		else $error("transmit pin not driven while enabled");
	chk_single_wire_dir: assert property (s_reg.cfg[CFG_LOOPBACK_SEL] && s_reg.cfg[CFG_RX_SOURCE_SEL]
		&& !s_reg.cfg[CFG_SINGLE_WIRE_DIR] && !wr_cfg |=> !tx_pin_oe)
		else $error("single-wire input direction still driven");
	chk_idle_queued: assert property ((toggle_tx_enable and (s_reg.tx_state != TX_IDLE)) |=>
		s_reg.idle_pend ##[1:400] s_reg.tx_state == TX_PREAMBLE)
		else $error("idle character not queued");
	chk_pin_release: assert property (!s_reg.ctrl[CTRL_TX_ENABLE] && s_reg.tx_state == TX_IDLE
		&& !s_reg.break_pend && !s_reg.idle_pend && !s_reg.ctrl[CTRL_QUEUE_BREAK] && !wr_ctrl |=> !tx_pin_oe)
		else $error("transmit pin held after drain");
	chk_rx_pin_gpio: assert property ((!s_reg.ctrl[CTRL_RX_ENABLE] || s_reg.cfg[CFG_LOOPBACK_SEL])
		&& !wr_ctrl && !wr_cfg |=> rx_pin_released)
		else $error("receive pin not released");
	chk_standby_wake: assert property (s_reg.ctrl[CTRL_RX_STANDBY_REQ] && !s_reg.cfg[CFG_WAKE_SEL]
		&& rx_evt.idle_det && !wr_ctrl |=> !s_reg.ctrl[CTRL_RX_STANDBY_REQ])
		else $error("standby not cleared by idle wake");
	chk_break_repeat: assert property (s_reg.ctrl[CTRL_QUEUE_BREAK] && s_reg.tx_state == TX_IDLE
		|=> s_reg.tx_state == TX_BREAK)
		else $error("break not queued");
	chk_tx_buf_empty_flag_clear: assert property (((arm_tx_empty ##1 write_data_word) or (arm_tx_empty ##1 gap_then_write))
		|=> !s_reg.status[ST_TX_BUF_EMPTY])
		else $error("transmit empty not cleared");
	chk_status_read: assert property (reg_req.rd && reg_req.addr == STATUS_OFS |=> rd_data == $past(s_reg.status))
		else $error("status read data wrong");
	chk_baud_hold: assert property (!s_reg.baud_run |=> s_reg.presc == 12'h000 && !baud_tick)
		else $error("prescaler ran before enable");
endmodule : sci_control_status

// ===== include/sci_ctl_pkg.sv
// Constants, field positions and carrier types for the serial control/status block.
// Assumes a byte-wide register port and one 25 MHz clock.
package sci_ctl_pkg;
	// Register byte addresses
	localparam logic [7:0] DIV_OFS    = 8'h3C;
	localparam logic [7:0] CFG_OFS    = 8'h40;
	localparam logic [7:0] STATUS_OFS = 8'h44;
	localparam logic [7:0] CTRL_OFS   = 8'h48;
	localparam logic [7:0] DATA_OFS   = 8'h4C;

	// control_two_reg fields
	localparam int CTRL_TX_EMPTY_IRQ_EN = 7;
	localparam int CTRL_TX_DONE_IRQ_EN  = 6;
	localparam int CTRL_RX_FULL_IRQ_EN  = 5;
	localparam int CTRL_LINE_IDLE_IRQ_EN = 4;
	localparam int CTRL_TX_ENABLE       = 3;
	localparam int CTRL_RX_ENABLE       = 2;
	localparam int CTRL_RX_STANDBY_REQ  = 1;
	localparam int CTRL_QUEUE_BREAK     = 0;

	// status_one_reg fields
	localparam int ST_TX_BUF_EMPTY = 7;
	localparam int ST_TX_DONE      = 6;
	localparam int ST_RX_BUF_FULL  = 5;
	localparam int ST_LINE_IDLE    = 4;
	localparam int ST_OVERRUN      = 3;
	localparam int ST_NOISE        = 2;
	localparam int ST_FRAMING_ERR  = 1;
	localparam int ST_PARITY_ERR   = 0;

	// line configuration fields
	localparam int CFG_LOOPBACK_SEL    = 7;
	localparam int CFG_RX_SOURCE_SEL   = 5;
	localparam int CFG_WAKE_SEL        = 3;
	localparam int CFG_LONG_BREAK_SEL  = 2;
	localparam int CFG_SINGLE_WIRE_DIR = 1;

	// Reset values
	localparam logic [7:0] STATUS_RESET = 8'hC0;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] CFG_RESET    = 8'h00;
	localparam logic [7:0] DIV_RESET    = 8'h01;

	// Character lengths in bit times
	localparam logic [3:0] FRAME_BITS      = 4'hA;
	localparam logic [3:0] LONG_BREAK_BITS = 4'hD;

	typedef enum logic [3:0] {
		TX_IDLE     = 4'h1,
		TX_DATA     = 4'h2,
		TX_BREAK    = 4'h4,
		TX_PREAMBLE = 4'h8
	} tx_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_s;

	typedef struct packed {
		logic       char_valid;
		logic [7:0] char_data;
		logic       idle_det;
		logic       noise;
		logic       frame_err;
		logic       parity_err;
	} rx_event_s;

	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  cfg;
		logic [7:0]  div;
		logic [7:0]  status;
		logic [7:0]  armed;
		logic [7:0]  rx_data;
		logic [7:0]  tx_buf;
		logic        baud_run;
		logic [11:0] presc;
		tx_state_e   tx_state;
		logic [12:0] shift;
		logic [3:0]  bit_cnt;
		logic        break_pend;
		logic        idle_pend;
		logic        idle_rearm;
		logic [7:0]  rd_data;
		logic        irq;
		logic        tx_out;
		logic        tx_oe;
		logic        rx_released;
	} sci_state_s;
endpackage : sci_ctl_pkg

// ===== verif/sci_control_and_status_tb.sv
// Self-checking bench for the serial control and status block.
// Assumes the remote node model and a bit time shortened to BIT clocks.
module sci_control_and_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sci_ctl_pkg::*;
	localparam int BIT = 4;
	typedef struct packed {
		logic [7:0] ctrl;
		logic       irq;
	} row_s;
	localparam row_s ROWS [0:5] = '{'{8'h80, 1'b1}, '{8'h40, 1'b1}, '{8'h20, 1'b0},
		'{8'h10, 1'b0}, '{8'h30, 1'b0}, '{8'h00, 1'b0}};
	logic       core_clk;
	logic       reset_n;
	bus_req_s   reg_req;
	logic [7:0] rd_data;
	rx_event_s  rx_evt;
	logic       irq_req;
	logic       tx_pin_out;
	logic       tx_pin_oe;
	logic       rx_pin_released;
	logic [7:0] got;
	int         n0;
	int         n1;
	int         n_mismatch = 0;
	int         num_checks = 0;
	int         cycles = 0;
	sci_control_status #(.OVERSAMPLE(BIT)) DUT (.core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req),
		.rd_data(rd_data), .rx_evt(rx_evt), .irq_req(irq_req), .tx_pin_out(tx_pin_out),
		.tx_pin_oe(tx_pin_oe), .rx_pin_released(rx_pin_released));
	sci_far_node #(.BIT(BIT)) FAR (.core_clk(core_clk), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
		.rx_evt(rx_evt));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic summarize();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		reg_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		reg_req.rd <= 1'b0;
		#1 got = rd_data;
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	task automatic wait_frame(input int start);
		for (int i = 0; i < 60 * BIT && FAR.n_frames == start; i++) @(posedge core_clk);
		#1;
	endtask : wait_frame
	initial begin
		reset_n = 1'b0;
		reg_req = '0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		#1 chk({tx_pin_out, tx_pin_oe, rx_pin_released, irq_req, rd_data[3:0]}, 8'hA0);
		wr(STATUS_OFS, 8'h00);
		rd(STATUS_OFS);
		chk(got, 8'hC0);
		rd(8'h50);
		chk(got, 8'h00);
		foreach (ROWS[i]) begin
			wr(CTRL_OFS, ROWS[i].ctrl);
			tick(2);
			chk({7'h00, irq_req}, {7'h00, ROWS[i].irq});
			rd(CTRL_OFS);
			chk(got, ROWS[i].ctrl);
		end
		// Receive flags, overrun and the read-status-then-read-data clear
		wr(CTRL_OFS, 8'h24);
		tick(2);
		chk({7'h00, rx_pin_released}, 8'h00);
		FAR.send(8'h5A, 1'b0);
		tick(2);
		chk({7'h00, irq_req}, 8'h01);
		FAR.send(8'h00, 1'b1);
		wr(CTRL_OFS, 8'h14);
		tick(2);
		chk({7'h00, irq_req}, 8'h01);
		FAR.send(8'h33, 1'b0);
		rd(STATUS_OFS);
		chk(got, 8'hF8);
		rd(DATA_OFS);
		chk(got, 8'h5A);
		rd(STATUS_OFS);
		chk(got, 8'hC0);
		wr(CFG_OFS, 8'h80);
		tick(2);
		chk({7'h00, rx_pin_released}, 8'h01);
		// Standby: wrong event keeps it, selected event ends it
		for (int w = 0; w < 2; w++) begin
			wr(CFG_OFS, (w == 1) ? 8'h08 : 8'h00);
			wr(CTRL_OFS, 8'h06);
			FAR.send(8'h80, w == 1);
			rd(CTRL_OFS);
			chk(got, 8'h06);
			FAR.send(8'h80, w == 0);
			rd(CTRL_OFS);
			chk(got, 8'h04);
		end
		wr(CTRL_OFS, 8'h00);
		wr(CFG_OFS, 8'hA0);
		wr(CTRL_OFS, 8'h08);
		tick(1);
		chk({7'h00, tx_pin_oe}, 8'h00);
		wr(CFG_OFS, 8'hA2);
		tick(1);
		chk({7'h00, tx_pin_oe}, 8'h01);
		wr(CFG_OFS, 8'h00);
		wr(CTRL_OFS, 8'h00);
		tick(1);
		chk({7'h00, tx_pin_oe}, 8'h01);
		tick(14 * BIT);
		chk({7'h00, tx_pin_oe}, 8'h00);
		// Buffer written with the transmitter off stays unsent
		rd(STATUS_OFS);
		wr(DATA_OFS, 8'hA5);
		rd(STATUS_OFS);
		chk(got & 8'hC0, 8'h00);
		n0 = FAR.n_frames;
		wr(CTRL_OFS, 8'h08);
		wait_frame(n0);
		chk(FAR.rx_byte, 8'hA5);
		tick(2 * BIT);
		n0 = FAR.n_frames;
		rd(STATUS_OFS);
		wr(DATA_OFS, 8'h3C);
		wr(CTRL_OFS, 8'h00);
		wait_frame(n0);
		chk(FAR.rx_byte, 8'h3C);
		tick(3 * BIT);
		chk({7'h00, tx_pin_oe}, 8'h00);
		// Enable toggled during a preamble queues a second idle before the data
		rd(STATUS_OFS);
		wr(DATA_OFS, 8'h96);
		wr(CTRL_OFS, 8'h08);
		wr(CTRL_OFS, 8'h00);
		wr(CTRL_OFS, 8'h08);
		n1 = cycles;
		n0 = FAR.n_frames;
		wait_frame(n0);
		// Two idle characters, each with its gap bit, come first
		chk({7'h00, (cycles - n1) > 22 * BIT}, 8'h01);
		chk(FAR.rx_byte, 8'h96);
		tick(2 * BIT);
		// Single break, normal then long
		for (int l = 0; l < 2; l++) begin
			wr(CFG_OFS, (l == 1) ? 8'h04 : 8'h00);
			n0 = FAR.n_frames;
			wr(CTRL_OFS, 8'h09);
			wr(CTRL_OFS, 8'h08);
			wait_frame(n0);
			tick(5 * BIT);
			chk(FAR.low_len, (l == 1) ? 8'(13 * BIT) : 8'(10 * BIT));
			tick(30 * BIT);
		end
		// Breaks repeat while the request is held
		n0 = FAR.n_frames;
		wr(CTRL_OFS, 8'h09);
		tick(30 * BIT);
		wr(CTRL_OFS, 8'h08);
		chk(8'(FAR.n_frames - n0), 8'h02);
		// Reset in mid-break returns every output to its idle level
		reset_n <= 1'b0;
		tick(2);
		chk({tx_pin_out, tx_pin_oe, rx_pin_released, irq_req, rd_data[3:0]}, 8'hA0);
		reset_n <= 1'b1;
		rd(STATUS_OFS);
		chk(got, 8'hC0);
		summarize();
	end
endmodule : sci_control_and_status_tb

// ===== verif/sci_far_node.sv
// Remote serial node: decodes the transmit line and injects receiver events.
// Assumes one bit time is BIT core_clk cycles and that the bench calls send().
module sci_far_node #(
	parameter int BIT = 4
) (
	input  wire logic           core_clk,
	input  wire logic           tx_pin_out,
	input  wire logic           tx_pin_oe,
	output sci_ctl_pkg::rx_event_s rx_evt
);
	timeunit 1ns;
	timeprecision 1ns;
	import sci_ctl_pkg::*;
	logic       line;
	logic [7:0] low_run = 8'h00;
	logic [7:0] low_len = 8'h00;
	logic [7:0] rx_byte = 8'h00;
	int         n_frames = 0;
	// Line pulled up while the block lets go of it
	assign line = (tx_pin_oe === 1'b1) ? tx_pin_out : 1'b1;
	initial rx_evt = '0;
	// Length of the latest low run, in clocks
	always @(posedge core_clk) begin
		if (line === 1'b0) begin
			low_run <= low_run + 8'h01;
		end else begin
			if (low_run != 8'h00) begin
				low_len <= low_run;
			end
			low_run <= 8'h00;
		end
	end
	// Start, eight bits LSB first, stop
	always begin
		@(negedge line);
		repeat (BIT / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge core_clk);
			rx_byte[i] = line;
		end
		repeat (BIT) @(posedge core_clk);
		n_frames++;
	end
	// One-cycle character or idle-line event; data inverted once stale
	task automatic send(input logic [7:0] d, input logic idle);
		@(posedge core_clk);
		rx_evt <= '{char_valid: !idle, char_data: d, idle_det: idle, default: 1'b0};
		@(posedge core_clk);
		rx_evt <= '{char_valid: 1'b0, char_data: ~d, idle_det: 1'b0, default: 1'b0};
	endtask : send
endmodule : sci_far_node
